// File: logic/bp_pkg.sv
// Purpose: constants, field layout and helpers of the breakpoint unit
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: byte offsets are paddr[11:0]; region in [11:8], channel in [6:4]
// Overview of operation
// - Build holds no breakpoints, 2 data plus 4 instr, or 4 plus 8 with complex.
// - Equality mode: each PC bit equals the stored bit or is masked.
// - Evaluate every executed instruction, address errors too; never speculative or unaligned ones.
// - Instruction match indication belongs to exactly the matching instruction.
// - Nothing matches while the core runs in debug mode.
// - Separate exception and trigger enables per breakpoint; a match fires the enabled ones.
// - Data breakpoints match loads, stores, or both.
// - Data match compares type, address, byte lanes and value; sets a hit bit if exception or trigger is enabled.
// - Optional value compare with per-byte exclusion, plus address masking.
// - Data exception or trigger belongs to the very load or store.
// - In range mode the address register is upper bound, mask register lower bound.
// - Read-only bit 6 of instruction control reads 1 when range matching exists.
// - Bit 5 of instruction control: 0 inside range, 1 outside range.
// - Bit 4 of instruction control: 0 equality and mask, 1 range.
// - Accesses straddling a range bound match both inside and outside settings.
// - Range bounds are two full 32-bit values, no power-of-two alignment.
// - Pass counter decrements per match; effect enabled only once it reads zero.
// - Tuple needs instruction match on the load/store PC and data match.
// - Primed breakpoint stays off until its source condition is seen.
// - Qualifying load matching address and value enables; value mismatch disables.
// - Stopwatch runs freely or starts and stops on instruction breakpoints.
// - A breakpoint raising an exception sets its status hit bit.
package bp_pkg;

    // Build options
    localparam int CFG_NONE  = 0;
    localparam int CFG_SMALL = 1;
    localparam int CFG_FULL  = 2;
    localparam int IB_MAX    = 8;
    localparam int DB_MAX    = 4;
    localparam int PASS_W    = 16;

    // Address regions and word indices
    localparam logic [3:0] RGN_GLB = 4'h0;
    localparam logic [3:0] RGN_IB  = 4'h1;
    localparam logic [3:0] RGN_DB  = 4'h2;
    localparam logic [1:0] GI_ISTAT = 2'h0;
    localparam logic [1:0] GI_DBS  = 2'h1;
    localparam logic [1:0] GI_SWC  = 2'h2;
    localparam logic [1:0] GI_SWN  = 2'h3;
    localparam logic [1:0] RI_CTRL = 2'h0;
    localparam logic [1:0] RI_ADDR = 2'h1;
    localparam logic [1:0] RI_MASK = 2'h2;
    localparam logic [1:0] RI_AUX  = 2'h3;

    // Control fields
    localparam int B_EXC   = 0;
    localparam int B_TRG   = 2;
    localparam int B_RNG   = 4;
    localparam int B_EXCL  = 5;
    localparam int B_RCAP  = 6;
    localparam int B_PRIME = 8;
    localparam int B_PSRC  = 9;
    localparam int B_QUAL  = 12;
    localparam int B_QSRC  = 13;
    localparam int B_NOLD  = 8;
    localparam int B_NOST  = 9;
    localparam int B_BAI   = 12;
    localparam int B_BLM   = 16;
    localparam int B_TUP   = 20;
    localparam int B_TSRC  = 21;
    localparam int B_IVM   = 24;
    localparam int SW_FREE  = 0;
    localparam int SW_TRIG  = 1;
    localparam int SW_START = 4;
    localparam int SW_STOP  = 8;
    localparam logic [31:0] IB_WMASK = 32'h0000_7F35;
    localparam logic [31:0] DB_WMASK = 32'h01FF_F335;
    localparam logic [31:0] SW_WMASK = 32'h0000_0773;

    // Arithmetic steps
    localparam logic [31:0]       LAST16   = 32'h0000_0001;
    localparam logic [31:0]       LAST32   = 32'h0000_0003;
    localparam logic [31:0]       SW_INC   = 32'h0000_0001;
    localparam logic [PASS_W-1:0] PASS_DEC = 16'h0001;

    function automatic logic mask_eq(input logic [31:0] v, r, m);
        return &(m | ~(v ^ r));
    endfunction : mask_eq

    // Bytes a..e against [lo, hi]; straddling hits either sense
    function automatic logic range_hit(input logic [31:0] a, e, lo, hi,
                                       input logic excl);
        logic strad;
        logic in_r;
        strad = (a < lo && e >= lo) || (a <= hi && e > hi);
        in_r  = a >= lo && e <= hi;
        return strad || (excl ? !in_r : in_r);
    endfunction : range_hit

    function automatic logic addr_ok(input logic [11:0] a, input int ni, nd);
        case (a[11:8])
            RGN_GLB: return a[7:4] == 4'h0;
            RGN_IB:  return !a[7] && int'(a[6:4]) < ni;
            RGN_DB:  return !a[7] && int'(a[6:4]) < nd;
            default: return 1'b0;
        endcase
    endfunction : addr_ok

endpackage : bp_pkg

// File: logic/dbp_match.sv
// Purpose: compare of one data breakpoint channel
// Assumes: lanes mark bytes of the aligned word at ls_addr
// Notes: addr_hit and val_ok split so qualification can use each
`timescale 1ns/1ps
`default_nettype none
module dbp_match
    import bp_pkg::*;
#(
    parameter logic RANGE_OK = 1'b1
) (
    // Transaction
    input  wire logic        ls_store,
    input  wire logic [31:0] ls_addr,
    input  wire logic [3:0]  ls_lanes,
    input  wire logic [31:0] ls_data,
    // Channel registers
    input  wire logic [31:0] ctl,
    input  wire logic [31:0] baddr,
    input  wire logic [31:0] bmask,
    input  wire logic [31:0] bval,
    // Result
    output logic             addr_hit,
    output logic             val_ok
);
    logic [3:0]  bai;
    logic [3:0]  blm;
    logic [3:0]  vb;
    logic [1:0]  lo_b;
    logic [1:0]  hi_b;
    logic        type_ok;
    logic        cmp;

    assign bai     = ctl[B_BAI +: 4];
    assign blm     = ctl[B_BLM +: 4];
    assign type_ok = ls_store ? !ctl[B_NOST] : !ctl[B_NOLD];
    assign lo_b = ls_lanes[0] ? 2'h0 : ls_lanes[1] ? 2'h1 : ls_lanes[2] ? 2'h2 : 2'h3;
    assign hi_b = ls_lanes[3] ? 2'h3 : ls_lanes[2] ? 2'h2 : ls_lanes[1] ? 2'h1 : 2'h0;
    assign cmp = (RANGE_OK && ctl[B_RNG])
               ? range_hit({ls_addr[31:2], lo_b}, {ls_addr[31:2], hi_b},
                           bmask, baddr, ctl[B_EXCL])
               : mask_eq(ls_addr, baddr, bmask);
    assign addr_hit = type_ok && |(ls_lanes & ~bai) && cmp;

    for (genvar b = 0; b < 4; b++) begin : g_byte
        assign vb[b] = ls_data[8*b +: 8] == bval[8*b +: 8] || !ls_lanes[b] || blm[b] || bai[b];
    end
    // No byte left to compare means value is ignored
    assign val_ok = &(~ls_lanes | blm | bai) || (ctl[B_IVM] ^ &vb);
endmodule : dbp_match
`default_nettype wire

// File: logic/hw_breakpoint_unit.sv
// Purpose: hardware breakpoint unit with APB register access
// Assumes: pipeline inputs on pclk; ex_valid only for retired, aligned instructions
// Notes: indications come one cycle after the matching instruction
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hw_breakpoint_unit
    import bp_pkg::*;
#(
    parameter int   CFG      = CFG_FULL,
    parameter logic RANGE_OK = 1'b1
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Executed instruction
    input  wire logic               debug_mode,
    input  wire logic               ex_valid,
    input  wire logic [31:0]        ex_pc,
    input  wire logic               ex_len32,
    // Load/store
    input  wire logic               ls_valid,
    input  wire logic               ls_store,
    input  wire logic [31:0]        ls_pc,
    input  wire logic [31:0]        ls_addr,
    input  wire logic [3:0]         ls_lanes,
    input  wire logic [31:0]        ls_data,
    // Indications
    output logic                    ib_exc,
    output logic [IB_MAX-1:0]       ib_trig,
    output logic                    db_exc,
    output logic [DB_MAX-1:0]       db_trig
);
    localparam int   NI = (CFG == CFG_FULL) ? 8 : (CFG == CFG_SMALL) ? 4 : 0;
    localparam int   ND = (CFG == CFG_FULL) ? 4 : (CFG == CFG_SMALL) ? 2 : 0;
    localparam logic CX = CFG == CFG_FULL;

    typedef struct packed {
        logic [IB_MAX-1:0][31:0]       ic;
        logic [IB_MAX-1:0][31:0]       ia;
        logic [IB_MAX-1:0][31:0]       im;
        logic [IB_MAX-1:0][PASS_W-1:0] pcnt;
        logic [IB_MAX-1:0]             arm;
        logic [IB_MAX-1:0]             qok;
        logic [IB_MAX-1:0]             ihit;
        logic [IB_MAX-1:0]             itrg;
        logic                          iexc;
        logic [DB_MAX-1:0][31:0]       dc;
        logic [DB_MAX-1:0][31:0]       da;
        logic [DB_MAX-1:0][31:0]       dm;
        logic [DB_MAX-1:0][31:0]       dv;
        logic [DB_MAX-1:0]             dhit;
        logic [DB_MAX-1:0]             dtrg;
        logic                          dexc;
        logic [31:0]                   swc;
        logic [31:0]                   swn;
        logic                          run;
        logic                          pready;
        logic                          pslverr;
        logic [31:0]                   prdata;
    } state_t;

    state_t            st_r;
    state_t            st_nxt;
    logic [IB_MAX-1:0] ihit_ex;
    logic [IB_MAX-1:0] ihit_ls;
    logic [IB_MAX-1:0] iraw;
    logic [IB_MAX-1:0] iexc_v;
    logic [DB_MAX-1:0] dadr;
    logic [DB_MAX-1:0] dval;
    logic [DB_MAX-1:0] draw;
    logic [DB_MAX-1:0] dexc_v;

    for (genvar g = 0; g < IB_MAX; g++) begin : g_ib
        if (g < NI) begin : g_on
            ibp_match #(.RANGE_OK(RANGE_OK)) u_ex (
                .pc    (ex_pc),
                .len32 (ex_len32),
                .ctl   (st_r.ic[g]),
                .baddr (st_r.ia[g]),
                .bmask (st_r.im[g]),
                .hit   (ihit_ex[g])
            );
            // Same channel seen from the load/store PC, for tuples
            ibp_match #(.RANGE_OK(RANGE_OK)) u_ls (
                .pc    (ls_pc),
                .len32 (1'b1),
                .ctl   (st_r.ic[g]),
                .baddr (st_r.ia[g]),
                .bmask (st_r.im[g]),
                .hit   (ihit_ls[g])
            );
        end else begin : g_off
            assign ihit_ex[g] = 1'b0;
            assign ihit_ls[g] = 1'b0;
        end
    end

    for (genvar g = 0; g < DB_MAX; g++) begin : g_db
        if (g < ND) begin : g_on
            dbp_match #(.RANGE_OK(RANGE_OK)) u_db (
                .ls_store (ls_store),
                .ls_addr  (ls_addr),
                .ls_lanes (ls_lanes),
                .ls_data  (ls_data),
                .ctl      (st_r.dc[g]),
                .baddr    (st_r.da[g]),
                .bmask    (st_r.dm[g]),
                .bval     (st_r.dv[g]),
                .addr_hit (dadr[g]),
                .val_ok   (dval[g])
            );
        end else begin : g_off
            assign dadr[g] = 1'b0;
            assign dval[g] = 1'b0;
        end
    end

    // Pipeline filters retired work; debug mode masks all
    assign iraw = (ex_valid && !debug_mode) ? ihit_ex : '0;
    assign draw = (ls_valid && !debug_mode) ? (dadr & dval) : '0;

    always_comb begin
        logic [31:0] rd;
        logic [31:0] ctl;
        logic [2:0]  ch;
        logic [1:0]  ri;
        logic        ok;
        logic        setup;
        logic        wr;
        logic        sw_wr;
        logic        go;
        logic        fire;
        rd     = '0;
        ctl    = '0;
        ch     = paddr[6:4];
        ri     = paddr[3:2];
        ok     = addr_ok(paddr, NI, ND);
        setup  = psel && !penable;
        wr     = psel && penable && st_r.pready && pwrite && ok;
        sw_wr  = wr && paddr[11:8] == RGN_GLB && ri == GI_SWN;
        go     = 1'b0;
        fire   = 1'b0;
        iexc_v = '0;
        dexc_v = '0;
        st_nxt = st_r;

        // Read data sampled at setup, presented in access phase
        case (paddr[11:8])
            RGN_GLB: begin
                case (ri)
                    GI_ISTAT: rd = 32'(st_r.ihit);
                    GI_DBS:  rd = 32'(st_r.dhit);
                    GI_SWC:  rd = st_r.swc;
                    default: rd = st_r.swn;
                endcase
            end
            RGN_IB: begin
                case (ri)
                    RI_CTRL: rd = st_r.ic[ch] | (32'(RANGE_OK) << B_RCAP);
                    RI_ADDR: rd = st_r.ia[ch];
                    RI_MASK: rd = st_r.im[ch];
                    default: rd = 32'(st_r.pcnt[ch]);
                endcase
            end
            RGN_DB: begin
                case (ri)
                    RI_CTRL: rd = st_r.dc[ch[1:0]] | (32'(RANGE_OK) << B_RCAP);
                    RI_ADDR: rd = st_r.da[ch[1:0]];
                    RI_MASK: rd = st_r.dm[ch[1:0]];
                    default: rd = st_r.dv[ch[1:0]];
                endcase
            end
            default: rd = '0;
        endcase
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup && !ok;
        st_nxt.prdata  = (setup && ok && !pwrite) ? rd : '0;

        // Writes first so that hardware events below win, except that a stopwatch count write beats its increment
        if (wr) begin
            case (paddr[11:8])
                RGN_GLB: begin
                    case (ri)
                        GI_ISTAT: st_nxt.ihit = st_r.ihit & ~pwdata[IB_MAX-1:0];
                        GI_DBS:  st_nxt.dhit = st_r.dhit & ~pwdata[DB_MAX-1:0];
                        GI_SWC:  st_nxt.swc = pwdata & SW_WMASK;
                        default: st_nxt.swn = pwdata;
                    endcase
                end
                RGN_IB: begin
                    case (ri)
                        RI_CTRL: begin
                            st_nxt.ic[ch]  = pwdata & IB_WMASK;
                            st_nxt.arm[ch] = 1'b0;
                            st_nxt.qok[ch] = 1'b0;
                        end
                        RI_ADDR: st_nxt.ia[ch] = pwdata;
                        RI_MASK: st_nxt.im[ch] = pwdata;
                        default: st_nxt.pcnt[ch] = pwdata[PASS_W-1:0];
                    endcase
                end
                RGN_DB: begin
                    case (ri)
                        RI_CTRL: st_nxt.dc[ch[1:0]] = pwdata & DB_WMASK;
                        RI_ADDR: st_nxt.da[ch[1:0]] = pwdata;
                        RI_MASK: st_nxt.dm[ch[1:0]] = pwdata;
                        default: st_nxt.dv[ch[1:0]] = pwdata;
                    endcase
                end
                default: ;
            endcase
        end

        for (int i = 0; i < NI; i++) begin
            ctl = st_r.ic[i];
            go  = !CX || ((!ctl[B_PRIME] || st_r.arm[i]) && (!ctl[B_QUAL] || st_r.qok[i])
                  && st_r.pcnt[i] == '0);
            if (CX && iraw[i] && st_r.pcnt[i] != '0) begin
                st_nxt.pcnt[i] = st_r.pcnt[i] - PASS_DEC;
            end
            if (CX && ctl[B_PRIME] && iraw[ctl[B_PSRC +: 3]]) begin
                st_nxt.arm[i] = 1'b1;
            end
            if (CX && ctl[B_QUAL] && ls_valid && !ls_store && !debug_mode
                && dadr[ctl[B_QSRC +: 2]]) begin
                st_nxt.qok[i] = dval[ctl[B_QSRC +: 2]];
            end
            iexc_v[i]      = iraw[i] && go && ctl[B_EXC];
            st_nxt.itrg[i] = iraw[i] && go && ctl[B_TRG];
            if (iexc_v[i]) begin
                st_nxt.ihit[i] = 1'b1;
            end
        end
        st_nxt.iexc = |iexc_v;

        for (int j = 0; j < ND; j++) begin
            ctl  = st_r.dc[j];
            fire = draw[j] && (!CX || !ctl[B_TUP] || ihit_ls[ctl[B_TSRC +: 3]]);
            dexc_v[j]      = fire && ctl[B_EXC];
            st_nxt.dtrg[j] = fire && ctl[B_TRG];
            if (fire && (ctl[B_EXC] || ctl[B_TRG])) begin
                st_nxt.dhit[j] = 1'b1;
            end
        end
        st_nxt.dexc = |dexc_v;

        // Stop wins over start when both hit together
        if (CX) begin
            if (st_r.swc[SW_TRIG] && iraw[st_r.swc[SW_START +: 3]]) begin
                st_nxt.run = 1'b1;
            end
            if (st_r.swc[SW_TRIG] && iraw[st_r.swc[SW_STOP +: 3]]) begin
                st_nxt.run = 1'b0;
            end
            if (!sw_wr && (st_r.swc[SW_FREE] || st_r.run)) begin
                st_nxt.swn = st_r.swn + SW_INC;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready  = st_r.pready;
    assign prdata  = st_r.prdata;
    assign pslverr = st_r.pslverr;
    assign ib_exc  = st_r.iexc;
    assign ib_trig = st_r.itrg;
    assign db_exc  = st_r.dexc;
    assign db_trig = st_r.dtrg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup phase not answered in next cycle");

    debug_quiet_a: assert property (debug_mode |=> !ib_exc && !db_exc && ib_trig == '0 && db_trig == '0)
        else $error("breakpoint fired for debug mode work");

    ib_precise_a: assert property (ib_trig[0] |-> $past(iraw[0]) && $past(st_r.ic[0][B_TRG]))
        else $error("trigger without a matching instruction");

    ib_hit_set_a: assert property (iexc_v[0] |=> st_r.ihit[0] && ib_exc)
        else $error("exception did not set its hit bit");

    pass_count_a: assert property (CX && iraw[0] && st_r.pcnt[0] != '0 |=> st_r.pcnt[0] == $past(st_r.pcnt[0]) - PASS_DEC)
        else $error("pass counter did not step down");

    pass_block_a: assert property (CX && st_r.pcnt[0] != '0 |=> !ib_trig[0])
        else $error("effect while pass counter nonzero");

    prime_hold_a: assert property (CX && st_r.ic[0][B_PRIME] && !st_r.arm[0] |=> !ib_trig[0])
        else $error("primed breakpoint fired before arming");

    db_hit_a: assert property (draw[0] && !st_r.dc[0][B_TUP] && st_r.dc[0][B_EXC] |=> db_exc && st_r.dhit[0])
        else $error("data match lost its exception or hit bit");

    sw_free_a: assert property (CX && st_r.swc[SW_FREE] && !(psel && penable && pwrite) |=> st_r.swn == $past(st_r.swn) + SW_INC)
        else $error("free running stopwatch did not count");

endmodule : hw_breakpoint_unit
`default_nettype wire

// File: logic/ibp_match.sv
// Purpose: address compare of one instruction breakpoint channel
// Assumes: registers and PC arrive on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module ibp_match
    import bp_pkg::*;
#(
    parameter logic RANGE_OK = 1'b1
) (
    // Instruction
    input  wire logic [31:0] pc,
    input  wire logic        len32,
    // Channel registers
    input  wire logic [31:0] ctl,
    input  wire logic [31:0] baddr,
    input  wire logic [31:0] bmask,
    // Result
    output logic             hit
);
    logic [31:0] last;

    assign last = pc + (len32 ? LAST32 : LAST16);
    // Upper bound in address reg, lower in mask reg
    assign hit = (RANGE_OK && ctl[B_RNG])
               ? range_hit(pc, last, bmask, baddr, ctl[B_EXCL])
               : mask_eq(pc, baddr, bmask);
endmodule : ibp_match
`default_nettype wire

// File: verification/hardware_breakpoint_unit_bench.sv
// Purpose: self-checking bench of the breakpoint unit against a small model
// Assumes: full build with range capability
// Notes: channel 0 of each kind carries the traffic; others stay disabled
`timescale 1ns/1ps
`default_nettype none
module hardware_breakpoint_unit_bench;
    import bp_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic              debug_mode, ex_valid, ex_len32, ls_valid, ls_store, ib_exc, db_exc;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, ex_pc, ls_pc, ls_addr, ls_data, q, a0, v;
    logic [3:0]        ls_lanes;
    logic [IB_MAX-1:0] ib_trig;
    logic [DB_MAX-1:0] db_trig;
    logic [31:0]       m_ctl, m_addr, m_mask, m_dctl, m_daddr, m_dval;
    logic [31:0]       seed = 32'h8A7A698B;
    logic [31:0]       rpc [6] = '{32'h1234, 32'h1232, 32'h5676, 32'h5678, 32'h1000, 32'h6000};
    int                m_pass, err_total, compares, cycles;

    hw_breakpoint_unit u_hw_breakpoint_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .debug_mode(debug_mode), .ex_valid(ex_valid),
        .ex_pc(ex_pc), .ex_len32(ex_len32), .ls_valid(ls_valid), .ls_store(ls_store),
        .ls_pc(ls_pc), .ls_addr(ls_addr), .ls_lanes(ls_lanes), .ls_data(ls_data),
        .ib_exc(ib_exc), .ib_trig(ib_trig), .db_exc(db_exc), .db_trig(db_trig));
    pipe_model u_pipe_model (.pclk(pclk), .debug_mode(debug_mode), .ex_valid(ex_valid),
        .ex_pc(ex_pc), .ex_len32(ex_len32), .ls_valid(ls_valid), .ls_store(ls_store),
        .ls_pc(ls_pc), .ls_addr(ls_addr), .ls_lanes(ls_lanes), .ls_data(ls_data));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
        compares++;
        if (s !== x) begin
            err_total++;
            $display("BAD %0t %s seen %h want %h", $time, m, s, x);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : apb
    task automatic sw_span(input logic [31:0] d);
        apb(1'b0, 12'h00C, 32'h0, v, e);
        apb(1'b0, 12'h00C, 32'h0, q, e);
        chk(q - v, d, "stopwatch");
    endtask : sw_span
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
        case (a)
            12'h100: m_ctl = d;
            12'h104: m_addr = d;
            12'h108: m_mask = d;
            12'h10C: m_pass = int'(d[15:0]);
            12'h200: m_dctl = d;
            12'h204: m_daddr = d;
            12'h20C: m_dval = d;
            default: ;
        endcase
    endtask : wr
    // Range bytes pc..last, straddling either bound hits both senses
    function automatic logic exp_ib(input logic [31:0] pc, input logic l);
        logic [31:0] t;
        logic        s, i;
        t = pc + (l ? 32'h3 : 32'h1);
        if (!m_ctl[4])
            return &(m_mask | ~(pc ^ m_addr));
        s = (pc < m_mask && t >= m_mask) || (pc <= m_addr && t > m_addr);
        i = pc >= m_mask && t <= m_addr;
        return s || (m_ctl[5] ? !i : i);
    endfunction : exp_ib
    task automatic run_ib(input logic [31:0] pc, input logic l, input logic dbg);
        logic hit, fire;
        hit  = exp_ib(pc, l) && !dbg;
        fire = hit && m_pass == 0;
        if (hit && m_pass > 0)
            m_pass--;
        u_pipe_model.issue_ex(pc, l, dbg);
        #1;
        chk(32'(ib_exc), 32'(fire & m_ctl[0]), "ib exc");
        chk(32'(ib_trig), 32'(fire & m_ctl[2]), "ib trig");
    endtask : run_ib
    task automatic run_db(input logic st, input logic [31:0] a, input logic [31:0] d);
        logic hit;
        hit = a == m_daddr && !(st ? m_dctl[9] : m_dctl[8]) && (m_dctl[19:16] == 4'hF || d == m_dval);
        u_pipe_model.issue_ls(st, a, d);
        #1;
        chk(32'(db_exc), 32'(hit & m_dctl[0]), "db exc");
        chk(32'(db_trig), 32'(hit & m_dctl[2]), "db trig");
    endtask : run_db

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {m_ctl, m_addr, m_mask, m_dctl, m_daddr, m_dval} = '0;
        m_pass = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h100, 32'h0, q, e);
        chk(q, 32'h40, "ib ctl reset");
        chk(32'(e), 32'h0, "mapped err");
        apb(1'b0, 12'h300, 32'h0, q, e);
        chk(32'(e), 32'h1, "unmapped err");
        a0 = xs() & 32'hFFFF_FFFC;
        wr(12'h104, a0);
        wr(12'h108, 32'h0000_00F0);
        wr(12'h100, 32'h5);
        for (int k = 0; k < 8; k++)
            run_ib(a0 ^ (32'h2 << (k * 4)), k[0], 1'b0);
        run_ib(a0, 1'b1, 1'b1);
        run_ib(a0, 1'b1, 1'b0);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk(q, 32'h1, "ib status");
        wr(12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk(q, 32'h0, "ib status clear");
        wr(12'h100, 32'h4);
        run_ib(a0, 1'b0, 1'b0);
        wr(12'h104, 32'h5679);
        wr(12'h108, 32'h1234);
        for (int x = 0; x < 2; x++) begin
            wr(12'h100, 32'h15 | (32'(x) << 5));
            for (int p = 0; p < 6; p++)
                run_ib(rpc[p], 1'b1, 1'b0);
        end
        wr(12'h100, 32'h5);
        wr(12'h104, a0);
        wr(12'h108, 32'h0);
        wr(12'h10C, 32'h2);
        repeat (3) run_ib(a0, 1'b1, 1'b0);
        wr(12'h204, a0);
        wr(12'h208, 32'h0);
        wr(12'h200, 32'h000F_0201);
        run_db(1'b0, a0, xs());
        run_db(1'b1, a0, xs());
        run_db(1'b0, a0 ^ 32'h4, xs());
        v = xs();
        wr(12'h20C, v);
        wr(12'h200, 32'h0000_0005);
        run_db(1'b1, a0, v);
        run_db(1'b0, a0, v ^ 32'h100);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chk(q, 32'h1, "db status");
        wr(12'h008, 32'h1);
        sw_span(32'h3);
        wr(12'h008, 32'h0000_0102);
        run_ib(a0, 1'b1, 1'b0);
        sw_span(32'h3);
        run_ib(32'h0, 1'b1, 1'b0);
        sw_span(32'h0);
        tally_and_finish();
    end
endmodule : hardware_breakpoint_unit_bench
`default_nettype wire

// File: verification/pipe_model.sv
// Purpose: pipeline stand-in issuing executed instructions and load/stores
// Assumes: one transaction per call, driven just after pclk rises
// Notes: released buses carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    // Clock
    input  wire logic   pclk,
    // Pipeline outputs
    output logic        debug_mode,
    output logic        ex_valid,
    output logic [31:0] ex_pc,
    output logic        ex_len32,
    output logic        ls_valid,
    output logic        ls_store,
    output logic [31:0] ls_pc,
    output logic [31:0] ls_addr,
    output logic [3:0]  ls_lanes,
    output logic [31:0] ls_data
);
    initial begin
        {debug_mode, ex_valid, ex_len32, ls_valid, ls_store} = '0;
        {ex_pc, ls_pc, ls_addr, ls_data} = '0;
        ls_lanes = 4'h0;
    end
    // Only retired, aligned instructions are issued
    // No address-space identifier compare is ever set up
    task automatic issue_ex(input logic [31:0] pc, input logic l, input logic dbg);
        @(posedge pclk);
        debug_mode <= dbg;
        ex_valid   <= 1'b1;
        ex_pc      <= pc;
        ex_len32   <= l;
        @(posedge pclk);
        ex_valid   <= 1'b0;
        ex_pc      <= ~pc;
    endtask : issue_ex
    task automatic issue_ls(input logic st, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        debug_mode <= 1'b0;
        ls_valid   <= 1'b1;
        ls_store   <= st;
        ls_pc      <= 32'h0000_1000;
        ls_addr    <= a;
        ls_lanes   <= 4'hF;
        ls_data    <= d;
        @(posedge pclk);
        ls_valid   <= 1'b0;
        ls_addr    <= ~a;
        ls_data    <= ~d;
        ls_lanes   <= 4'h0;
    endtask : issue_ls
endmodule : pipe_model
`default_nettype wire
